// *** rtl/imp_regs.sv ***
// Mask, poll, peek, END_OF_INTERRUPT_MASTER and vector registers of the interrupt controller.
// Assumes a classic Wishbone master, one request in flight, 16-bit view
// in dat[15:0]; sources raise one-cycle request pulses.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module imp_regs
    import imp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [5:0] src_req_i,
    input wire logic cpu_ack_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [5:0] source_mask_bit_o,
    output logic [5:0] in_service_flags_o,
    output logic irq_o,
    output logic [7:0] irq_type_o,
    output logic [9:0] vector_offset_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    imp_bus_e bus_st;
    logic slave_mode;
    logic [5:0] mask;
    logic [4:0] type_upper_bits;
    logic [5:0] pend;
    logic [5:0] serv;
    logic [5:0] ack_vec;
    logic [5:0] eoi_vec;
    imp_pick_s pick;
    logic [9:0] idx;
    logic req_now;
    logic wr_now;
    logic rd_now;
    logic lo_en;
    logic hi_en;
    logic [15:0] wdat;
    logic [15:0] next_rdata;
    logic [2:0] pick_prio;
    logic [4:0] eoi_type;
    logic [2:0] eoi_prio;
    logic eoi_hit;
    logic poll_ack;

    assign idx = wb_adr_i[11:2];
    assign req_now = wb_cyc_i && wb_stb_i && (bus_st == BUS_IDLE);
    assign wr_now = req_now && wb_we_i;
    assign rd_now = req_now && !wb_we_i;
    assign lo_en = wb_sel_i[0];
    assign hi_en = wb_sel_i[1];
    assign wdat = wb_dat_i[15:0];

    // ------------------------------------------------------------
    // Bus handshake: ack one cycle after the strobe, then a rest cycle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            bus_st <= BUS_IDLE;
        else
        begin
            case (bus_st)
                BUS_IDLE: if (wb_cyc_i && wb_stb_i) bus_st <= BUS_ACK;
                BUS_ACK: bus_st <= BUS_DONE;
                BUS_DONE: if (!(wb_cyc_i && wb_stb_i)) bus_st <= BUS_IDLE;
                default: bus_st <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req_now;
    end

    // ------------------------------------------------------------
    // Mode select, kept in a word of its own (bit 0 = slave mode)
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            slave_mode <= 1'b0;
        else if (wr_now && lo_en && idx == IDX_MODE)
            slave_mode <= wdat[0];
    end

    // ------------------------------------------------------------
    // Mask register; bit 1 and upper bits are not implemented
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            mask <= MASK_RESET[5:0];
        else if (wr_now && lo_en && idx == IDX_MASK)
            mask <= wdat[5:0] & MASK_IMPL;
    end

    // ------------------------------------------------------------
    // Vector base; no reset, software must load it first
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (wr_now && lo_en && idx == IDX_VECTOR)
            type_upper_bits <= wdat[VEC_MSB:VEC_LSB];
    end

    // ------------------------------------------------------------
    // Priority pick among pending, unmasked sources
    // ------------------------------------------------------------
    function automatic logic [2:0] prio_of(input int b);
        case (b)
            BIT_TIMER0: prio_of = PRIO_TIMER0;
            BIT_DMA0: prio_of = PRIO_DMA0;
            BIT_DMA1: prio_of = PRIO_DMA1;
            BIT_TIMER1: prio_of = PRIO_TIMER1;
            default: prio_of = PRIO_TIMER2;
        endcase
    endfunction : prio_of

    function automatic logic [4:0] mtype_of(input int b);
        case (b)
            BIT_DMA0: mtype_of = TYPE_DMA0;
            BIT_DMA1: mtype_of = TYPE_DMA1;
            default: mtype_of = TYPE_TIMER;
        endcase
    endfunction : mtype_of

    always_comb
    begin
        pick = '0;
        pick_prio = 3'h0;
        // Lowest bit is highest priority; bit order matches level order
        for (int b = NUM_SRC - 1; b >= 0; b--)
        begin
            if (pend[b] && !mask[b] && MASK_IMPL[b])
            begin
                pick.pending = 1'b1;
                pick.onehot = 6'h01 << b;
                pick.kind = mtype_of(b);
                pick_prio = prio_of(b);
            end
        end
    end

    // Poll read acknowledges in master mode only; the peek address never does
    assign poll_ack = rd_now && !slave_mode && idx == IDX_POLL
        && pick.pending;
    assign ack_vec = (poll_ack || cpu_ack_i) ? pick.onehot : 6'h00;

    // ------------------------------------------------------------
    // END_OF_INTERRUPT_MASTER decode
    // ------------------------------------------------------------
    assign eoi_type = wdat[4:0];
    assign eoi_prio = wdat[2:0];
    assign eoi_hit = wr_now && lo_en && idx == IDX_EOI;

    always_comb
    begin
        eoi_vec = 6'h00;
        if (eoi_hit)
        begin
            if (slave_mode)
            begin
                for (int b = 0; b < NUM_SRC; b++)
                    if (MASK_IMPL[b] && prio_of(b) == eoi_prio)
                        eoi_vec[b] = 1'b1;
            end
            else if (hi_en && wdat[BIT_NONSPEC])
            begin
                // Non-specific: clear the highest in-service flag only
                for (int b = NUM_SRC - 1; b >= 0; b--)
                    if (serv[b])
                        eoi_vec = 6'h01 << b;
            end
            else
            begin
                for (int b = 0; b < NUM_SRC; b++)
                    if (MASK_IMPL[b] && mtype_of(b) == eoi_type)
                        eoi_vec[b] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Source slots
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_slot
        imp_src_slot u_slot (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .req_i(src_req_i[g]),
            .ack_i(ack_vec[g]),
            .eoi_i(eoi_vec[g]),
            .pend_o(pend[g]),
            .serv_o(serv[g])
        );
    end

    // ------------------------------------------------------------
    // Read mux; poll/peek writes fall through with no effect
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 16'h0000;
        case (idx)
            IDX_MASK: next_rdata = {10'h000, mask};
            IDX_POLL, IDX_PEEK:
            begin
                next_rdata[BIT_PENDING] = pick.pending;
                next_rdata[4:0] = pick.pending ? pick.kind : 5'h00;
            end
            IDX_VECTOR: next_rdata[VEC_MSB:VEC_LSB] = type_upper_bits;
            IDX_IN_SERVICE_FLAGS: next_rdata = {10'h000, serv};
            IDX_MODE: next_rdata = {15'h0000, slave_mode};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wb_dat_o <= 32'h0000_0000;
        else if (rd_now)
            wb_dat_o <= {16'h0000, next_rdata};
    end

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            source_mask_bit_o <= MASK_RESET[5:0];
            in_service_flags_o <= 6'h00;
            irq_o <= 1'b0;
            irq_type_o <= 8'h00;
            vector_offset_o <= 10'h000;
        end
        else
        begin
            source_mask_bit_o <= mask;
            in_service_flags_o <= serv;
            irq_o <= pick.pending;
            if (slave_mode)
            begin
                irq_type_o <= {type_upper_bits, pick_prio};
                // Top two bits of the padded type fall off the shift
                vector_offset_o <= {2'b00, type_upper_bits, pick_prio}
                    << VEC_SHIFT;
            end
            else
            begin
                irq_type_o <= {3'b000, pick.kind};
                vector_offset_o <= {5'h00, pick.kind}
                    << VEC_SHIFT;
            end
        end
    end

endmodule : imp_regs

// *** pkg/imp_pkg.sv ***
// Constants and carrier types for the interrupt mask, poll and END_OF_INTERRUPT_MASTER registers.
// Assumes a 16-bit register view placed in the low bits of a 32-bit
// classic Wishbone data bus; register offsets are word indices.
//
// Notes on behaviour
// - Slave mode: mask register write sets or clears per-source mask bits.
// - Slave mode: mask register read returns the per-source mask bits.
// - Mask register resets to 003dh, all sources masked.
// - Mask bits: timer2 5, timer1 4, dma1 3, dma0 2, timer0 0.
// - Master mode: peek register returns poll content, no acknowledge.
// - Master mode: poll read acknowledges current interrupt, next one shows.
// - Bit 15 of poll registers reads 1 while an interrupt is pending.
// - Low type field gives type of highest-priority pending interrupt.
// - Poll and peek registers are read-only; writes do nothing.
// - END_OF_INTERRUPT_MASTER write clears the selected in-service flag in both modes.
// - Master END_OF_INTERRUPT_MASTER: bit 15 set is non-specific, else type bits 4..0 select.
// - Slave END_OF_INTERRUPT_MASTER: priority in bits 2..0 clears that in-service bit.
// - END_OF_INTERRUPT_MASTER is write-only; slave contents undefined after reset.
// - Slave vector register holds type bits 7..3; others read zero.
// - Slave mode: low three type bits come from source priority level.
// - Vector table offset is the 8-bit type shifted left by two.
// - Slave vector register is undefined until software loads it.
// - Master mode: in-service bit set when the interrupt is taken.
package imp_pkg;

    // ------------------------------------------------------------
    // Register map (word indices; byte address is four times)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_VECTOR = 10'h020;
    localparam logic [9:0] IDX_EOI = 10'h022;
    localparam logic [9:0] IDX_POLL = 10'h024;
    localparam logic [9:0] IDX_PEEK = 10'h026;
    localparam logic [9:0] IDX_MASK = 10'h028;
    localparam logic [9:0] IDX_IN_SERVICE_FLAGS = 10'h02c;
    localparam logic [9:0] IDX_MODE = 10'h030;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam logic [5:0] MASK_IMPL = 6'h3d;
    localparam logic [15:0] MASK_RESET = 16'h003d;
    localparam int BIT_PENDING = 15;
    localparam int BIT_NONSPEC = 15;
    localparam int BIT_TIMER2 = 5;
    localparam int BIT_TIMER1 = 4;
    localparam int BIT_DMA1 = 3;
    localparam int BIT_DMA0 = 2;
    localparam int BIT_TIMER0 = 0;
    localparam int VEC_LSB = 3;
    localparam int VEC_MSB = 7;
    localparam int VEC_SHIFT = 2;

    // Fixed priority levels of the slave-mode sources, lowest wins
    localparam logic [2:0] PRIO_TIMER0 = 3'h0;
    localparam logic [2:0] PRIO_DMA0 = 3'h2;
    localparam logic [2:0] PRIO_DMA1 = 3'h3;
    localparam logic [2:0] PRIO_TIMER1 = 3'h4;
    localparam logic [2:0] PRIO_TIMER2 = 3'h5;

    // Master-mode interrupt type of each in-service bit
    localparam logic [4:0] TYPE_TIMER = 5'h08;
    localparam logic [4:0] TYPE_DMA0 = 5'h0a;
    localparam logic [4:0] TYPE_DMA1 = 5'h0b;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01,
        BUS_DONE = 2'b10
    } imp_bus_e;

    typedef struct packed {
        logic pending;
        logic [4:0] kind;
        logic [5:0] onehot;
    } imp_pick_s;

endpackage : imp_pkg

// *** rtl/imp_src_slot.sv ***
// One interrupt source slot: request latch and in-service flag.
// Assumes request pulses and acknowledge strobes are synchronous.
`timescale 1ns/1ns
module imp_src_slot
    import imp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic ack_i,
    input wire logic eoi_i,
    output logic pend_o,
    output logic serv_o
);

    // ------------------------------------------------------------
    // Request latch: new request wins over acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pend_o <= 1'b0;
        else if (req_i)
            pend_o <= 1'b1;
        else if (ack_i)
            pend_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // In-service flag: taking an interrupt wins over an END_OF_INTERRUPT_MASTER
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            serv_o <= 1'b0;
        else if (ack_i)
            serv_o <= 1'b1;
        else if (eoi_i)
            serv_o <= 1'b0;
    end

endmodule : imp_src_slot

// *** verification/imp_core_model.sv ***
// Core model: classic Wishbone master plus request and acknowledge pulses.
// Assumes one clock and a slave that answers with a one-cycle ack.
`timescale 1ns/1ns
module imp_core_model
(
    input wire logic core_clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [11:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    output logic [5:0] src_req_o,
    output logic cpu_ack_o
);
    // ------------------------------------------------------------
    // Bus cycles and pulses
    // ------------------------------------------------------------
    initial
    begin
        {wb_cyc_o, wb_stb_o, wb_we_o, cpu_ack_o} = 4'h0;
        wb_adr_o = 12'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
        src_req_o = 6'h00;
    end

    task xfer(input logic we, input logic [9:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        @(posedge core_clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'b00};
        wb_sel_o <= 4'h3;
        wb_dat_o <= {16'h0000, wd};
        @(posedge core_clk_i);
        // No fixed latency assumed; the bench timeout ends a hang
        while (wb_ack_i !== 1'b1)
            @(posedge core_clk_i);
        rd = wb_dat_i[15:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released data does not keep its last value
        wb_dat_o <= ~wb_dat_o;
    endtask : xfer

    task pulse(input logic [5:0] req, input logic ack);
        @(posedge core_clk_i);
        src_req_o <= req;
        cpu_ack_o <= ack;
        @(posedge core_clk_i);
        src_req_o <= 6'h00;
        cpu_ack_o <= 1'b0;
    endtask : pulse
endmodule : imp_core_model

// *** verification/imp_props.sv ***
// Checker for the mask, poll, END_OF_INTERRUPT_MASTER and vector register block.
// Assumes it is bound to imp_regs and sees only that module's ports.
`timescale 1ns/1ns
module imp_props
    import imp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [5:0] src_req_i,
    input wire logic cpu_ack_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [5:0] source_mask_bit_o,
    input wire logic [5:0] in_service_flags_o,
    input wire logic irq_o,
    input wire logic [7:0] irq_type_o,
    input wire logic [9:0] vector_offset_o
);
    // ------------------------------------------------------------
    // Register relations
    // ------------------------------------------------------------
    logic [9:0] idx;
    logic take;
    logic rd_ack;
    assign idx = wb_adr_i[11:2];
    // Ack cycle excluded so a held request is not counted twice
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_ack = wb_ack_o & ~wb_we_i;
    // Outputs lag a take by two edges: register, then output flop

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    mask_write_a: assert property (
        take && wb_we_i && idx == IDX_MASK && wb_sel_i[0] |-> ##2
        source_mask_bit_o == ($past(wb_dat_i[5:0], 2) & MASK_IMPL))
        else $error("mask write not applied");
    mask_read_a: assert property (
        rd_ack && idx == IDX_MASK |->
        wb_dat_o[15:0] == {10'h000, source_mask_bit_o})
        else $error("mask read differs from mask bits");
    mask_reserved_a: assert property (!source_mask_bit_o[1])
        else $error("reserved mask bit set");
    peek_quiet_a: assert property (
        take && !wb_we_i && idx == IDX_PEEK && !cpu_ack_i |-> ##2
        $stable(in_service_flags_o))
        else $error("peek read changed in-service flags");
    poll_format_a: assert property (
        rd_ack && (idx == IDX_POLL || idx == IDX_PEEK) |->
        wb_dat_o[14:5] == 10'h000)
        else $error("poll reserved bits not zero");
    poll_readonly_a: assert property (
        take && wb_we_i && (idx == IDX_POLL || idx == IDX_PEEK) &&
        !cpu_ack_i |-> ##2 $stable(in_service_flags_o))
        else $error("poll write changed state");
    eoi_no_set_a: assert property (
        take && wb_we_i && idx == IDX_EOI && !cpu_ack_i |-> ##2
        (in_service_flags_o & ~$past(in_service_flags_o)) == 6'h00)
        else $error("END_OF_INTERRUPT_MASTER write set an in-service flag");
    eoi_writeonly_a: assert property (
        rd_ack && idx == IDX_EOI |-> wb_dat_o == 32'h00000000)
        else $error("END_OF_INTERRUPT_MASTER read not zero");
    vector_zero_a: assert property (
        rd_ack && idx == IDX_VECTOR |->
        wb_dat_o[15:8] == 8'h00 && wb_dat_o[2:0] == 3'h0)
        else $error("vector reserved bits not zero");
    offset_scale_a: assert property (
        irq_o |-> vector_offset_o == {irq_type_o, 2'b00})
        else $error("vector offset not type times four");

    cover property (take && !wb_we_i && idx == IDX_POLL);
    cover property (take && wb_we_i && idx == IDX_EOI);
    cover property (cpu_ack_i && irq_o);
endmodule : imp_props

bind imp_regs imp_props u_props (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .src_req_i(src_req_i), .cpu_ack_i(cpu_ack_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .source_mask_bit_o(source_mask_bit_o),
    .in_service_flags_o(in_service_flags_o), .irq_o(irq_o),
    .irq_type_o(irq_type_o), .vector_offset_o(vector_offset_o));

// *** verification/tb_top.sv ***
// Self-checking bench for the mask, poll, END_OF_INTERRUPT_MASTER and vector registers.
// Assumes the core model drives every bus, request and acknowledge input.
`timescale 1ns/1ns
module tb_top
    import imp_pkg::*;
;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    logic core_clk_i;
    logic rstn_i;
    logic cyc, stb, we, ack, cack, irq;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [5:0] req, msk, isv;
    logic [7:0] ityp;
    logic [9:0] voff;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    imp_regs dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .src_req_i(req), .cpu_ack_i(cack),
        .wb_dat_o(rdat), .wb_ack_o(ack), .source_mask_bit_o(msk),
        .in_service_flags_o(isv), .irq_o(irq), .irq_type_o(ityp),
        .vector_offset_o(voff));
    imp_core_model core (.core_clk_i(core_clk_i), .wb_ack_i(ack),
        .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .src_req_o(req),
        .cpu_ack_o(cack));

    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task rd(input logic [9:0] idx, input logic [15:0] exp);
        logic [15:0] v;
        core.xfer(1'b0, idx, 16'h0000, v);
        check(v, exp);
    endtask : rd

    task wr(input logic [9:0] idx, input logic [15:0] v);
        logic [15:0] unused;
        core.xfer(1'b1, idx, v, unused);
    endtask : wr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task reset_values;
        rd(IDX_MASK, MASK_RESET);
        rd(IDX_PEEK, 16'h0000);
        rd(IDX_EOI, 16'h0000);
        rd(10'h03f, 16'h0000);
    endtask : reset_values

    task mask_walk;
        wr(IDX_MODE, 16'h0001);
        for (int i = 0; i < 16; i++)
        begin
            wr(IDX_MASK, 16'h0001 << i);
            rd(IDX_MASK, (16'h0001 << i) & MASK_RESET);
            check({10'h000, msk}, (16'h0001 << i) & MASK_RESET);
        end
    endtask : mask_walk

    task slave_type;
        wr(IDX_VECTOR, 16'hffff);
        rd(IDX_VECTOR, 16'h00f8);
        wr(IDX_MASK, MASK_RESET);
        core.pulse(6'h10, 1'b0);
        repeat (3) @(posedge core_clk_i);
        check({15'h0000, irq}, 16'h0000);
        wr(IDX_MASK, 16'h0000);
        repeat (3) @(posedge core_clk_i);
        check({15'h0000, irq}, 16'h0001);
        check({8'h00, ityp}, 16'h00fc);
        check({6'h00, voff}, 16'h03f0);
        core.pulse(6'h00, 1'b1);
        rd(IDX_IN_SERVICE_FLAGS, 16'h0010);
        wr(IDX_EOI, 16'h0005); // Other level first, must not clear
        rd(IDX_IN_SERVICE_FLAGS, 16'h0010);
        wr(IDX_EOI, 16'h0004); // END_OF_INTERRUPT_MASTER ahead of return
        rd(IDX_IN_SERVICE_FLAGS, 16'h0000);
    endtask : slave_type

    task master_poll;
        wr(IDX_MODE, 16'h0000);
        core.pulse(6'h0c, 1'b0);
        rd(IDX_PEEK, 16'h800a);
        rd(IDX_PEEK, 16'h800a);
        wr(IDX_POLL, 16'h0000);
        wr(IDX_PEEK, 16'h0000);
        rd(IDX_IN_SERVICE_FLAGS, 16'h0000);
        rd(IDX_POLL, 16'h800a);
        rd(IDX_IN_SERVICE_FLAGS, 16'h0004);
        check({10'h000, isv}, 16'h0004);
        rd(IDX_PEEK, 16'h800b);
        rd(IDX_POLL, 16'h800b);
        wr(IDX_EOI, 16'h000a); // Specific form ahead of return
        rd(IDX_IN_SERVICE_FLAGS, 16'h0008);
        wr(IDX_EOI, 16'h8000);
        rd(IDX_IN_SERVICE_FLAGS, 16'h0000);
        rd(IDX_PEEK, 16'h0000);
    endtask : master_poll

    task final_report;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Clock, reset, sequence and timeout
    // ------------------------------------------------------------
    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
    begin
        cycles++;
        // Whole sequence needs well under two thousand cycles
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    initial
    begin
        rstn_i = 1'b0;
        repeat (16) @(posedge core_clk_i);
        check({10'h000, msk}, MASK_RESET);
        rstn_i <= 1'b1;
        reset_values();
        mask_walk();
        slave_type();
        master_poll();
        final_report();
    end
endmodule : tb_top
